// ==== common/adcst_pkg.sv ====
// Package of constants and carrier types for the converter status register block.
package adcst_pkg;

    // Channel count and order code limits.
    localparam int NUM_CH = 6;
    localparam logic [2:0] ORD_ZERO = 3'h0;
    localparam logic [2:0] ORD_SEVEN = 3'h7;
    localparam logic [3:0] ORD_MAX = 4'h6;

    // Sequencer mode field encodings and the invalid calibration select value.
    localparam logic [1:0] MODE_SEQ1 = 2'h0;
    localparam logic [1:0] MODE_SEQ2 = 2'h1;
    localparam logic [1:0] MODE_SEQ3 = 2'h2;
    localparam logic [1:0] CAL_INVALID = 2'h3;

    // Field positions inside the 24-bit status word.
    localparam int BIT_RESET_ACTIVE = 22;
    localparam int SRDY_LSB = 16;
    localparam int BIT_SCAN_FAULT = 15;
    localparam int BIT_REF_PRESENT = 14;
    localparam int BIT_ORDER_FAULT = 13;
    localparam int BIT_PIN_FAULT = 12;
    localparam int BIT_CFG_ERROR = 11;
    localparam int PDSTAT_LSB = 2;
    localparam int BIT_MOD_BUSY = 1;
    localparam int BIT_RDY = 0;

    // Power state codes as reported in the status word.
    localparam logic [1:0] PD_CONVERSION = 2'h0;
    localparam logic [1:0] PD_SLEEP = 2'h1;
    localparam logic [1:0] PD_STANDBY = 2'h2;
    localparam logic [1:0] PD_RESET = 2'h3;

    // Status value while reset is asserted: reset flag set, power state reset.
    localparam logic [23:0] STATUS_RESET = 24'h40000C;

    // Cycles spent in the reset power state after reset is released.
    localparam logic [2:0] RESET_HOLD_CYCLES = 3'h4;

    // Reference detector settle window, derived from the 200 MHz clock.
    localparam int CLK_PERIOD_PS = 5000;
    localparam int REF_VALID_US = 30;
    localparam int REF_VALID_CYCLES = (REF_VALID_US * 1000000) / CLK_PERIOD_PS;

    // Power state of the converter core.
    typedef enum logic [1:0] {PS_RESET, PS_STANDBY, PS_CONVERT, PS_SLEEP} adcst_pstate_t;

    // One channel map entry.
    typedef struct packed {
        logic [1:0] pin_sel;
        logic [2:0] channel_order_code;
        logic channel_scan_enable;
        logic channel_pin_drive_enable;
    } adcst_chan_cfg_t;

    // Control fields that the fault checks inspect.
    typedef struct packed {
        logic [1:0] cal_select;
        logic single_cycle_select;
        logic [1:0] scan_mode;
        adcst_chan_cfg_t [NUM_CH-1:0] chan;
    } adcst_cfg_t;

    // Events and levels from the converter core and the serial port.
    typedef struct packed {
        logic conv_cmd;
        logic conv_done;
        logic cal_busy;
        logic sleep_req;
        logic scan_start;
        logic result_new;
        logic [2:0] result_chan;
        logic data_read_done;
        logic [2:0] read_chan;
        logic ref_ok;
    } adcst_evt_t;

    // Complete state of the status block.
    typedef struct packed {
        adcst_pstate_t pstate;
        logic [2:0] rst_cnt;
        logic [12:0] ref_cnt;
        logic [NUM_CH-1:0] srdy;
        logic rdy;
        logic abort;
        logic [23:0] status;
    } adcst_state_t;

endpackage : adcst_pkg

// ==== hw/adcst_status.sv ====
// Status register logic with configuration fault checks for the six-channel converter.
`timescale 1ns/1ps
// Overview of operation
// RL1 - Reset flag reads one while the device sits in its reset state.
// RL2 - In modes two and three a new channel result sets its ready bit.
// RL3 - A complete read of a channel data register clears its ready bit.
// RL4 - Every scan start clears all six channel ready bits. The code instead sets the bit of a new result arriving in the same cycle.
// RL5 - Modes two or three with no channel or order 000/111 flag scan fault.
// RL6 - Conversion commands are aborted while the scan fault is set.
// RL7 - Reference flag follows the detector; it never blocks conversion.
// RL8 - Reference flag reads zero in sleep or standby.
// RL9 - Reference flag is trusted only from 30 us after start inside conversion.
// RL10 - Two enabled channels sharing one order position flag an order fault.
// RL11 - An enabled channel with order code 000 or 111 flags an order fault.
// RL12 - Enabled orders must run gapless from 001; anything else is an order fault.
// RL13 - While an order fault persists the device stays in standby.
// RL14 - Two pin-driving channels on one output pin fault; device holds standby.
// RL15 - Calibration select equal to 11 sets the configuration error flag.
// RL16 - Single cycle select zero in modes two or three sets configuration error.
// RL17 - A configuration error moves the device to standby and holds it there.
// RL18 - In mode one a new result sets the ready bit; a full read clears it.
// RL19 - Modulator busy is one during conversion or calibration, else zero.
// RL20 - The status word is read only and built from internal state alone.
module adcst_status #(
    parameter logic [12:0] REF_VALID_CYCLES = 13'(adcst_pkg::REF_VALID_CYCLES)
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire adcst_pkg::adcst_cfg_t cfg,
    input wire adcst_pkg::adcst_evt_t evt,
    output logic [23:0] device_status,
    output logic conv_abort,
    output logic standby_hold,
    output logic reference_valid
);

    ////////////////////////////////////////////////////////////////////////////
    // Per-channel decode of the channel map.

    logic [adcst_pkg::NUM_CH-1:0] ch_bad_order;
    logic [adcst_pkg::NUM_CH-1:0] ch_en;
    logic [adcst_pkg::NUM_CH-1:0] ch_pin_clash;
    logic [7:0] ch_pos [adcst_pkg::NUM_CH];

    genvar gi;
    generate
        for (gi = 0; gi < adcst_pkg::NUM_CH; gi++) begin : g_chan
            logic [adcst_pkg::NUM_CH-1:0] clash;
            // Enabled channel with a forbidden order code.
            assign ch_en[gi] = cfg.chan[gi].channel_scan_enable;
            assign ch_bad_order[gi] = ch_en[gi] &&
                ((cfg.chan[gi].channel_order_code == adcst_pkg::ORD_ZERO) ||
                 (cfg.chan[gi].channel_order_code == adcst_pkg::ORD_SEVEN)); // RL11
            // One-hot scan position claimed by this channel, empty when disabled.
            assign ch_pos[gi] = ch_en[gi] ? (8'h01 << cfg.chan[gi].channel_order_code) : 8'h00;
            // A later channel driving the same output pin collides with this one.
            for (genvar gj = 0; gj < adcst_pkg::NUM_CH; gj++) begin : g_pair
                assign clash[gj] = (gj > gi) && cfg.chan[gi].channel_pin_drive_enable &&
                    cfg.chan[gj].channel_pin_drive_enable &&
                    (cfg.chan[gi].pin_sel == cfg.chan[gj].pin_sel); // RL14
            end
            assign ch_pin_clash[gi] = |clash;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Configuration fault checks.

    logic scan_mode_multi;
    logic scan_fault;
    logic order_fault;
    logic pin_fault;
    logic cfg_error;
    logic any_fault;
    logic [7:0] pos_used;
    logic [7:0] pos_expected;
    logic [3:0] en_count;

    // Scan mode two or three selects the multi-channel sequencer.
    assign scan_mode_multi = (cfg.scan_mode == adcst_pkg::MODE_SEQ2) ||
                             (cfg.scan_mode == adcst_pkg::MODE_SEQ3);

    // Gather claimed positions and build the gapless pattern 1..n for n enabled channels.
    always_comb begin
        pos_used = 8'h00;
        en_count = 4'h0;
        pos_expected = 8'h00;
        for (int i = 0; i < adcst_pkg::NUM_CH; i++) begin
            pos_used = pos_used | ch_pos[i];
            en_count = en_count + {3'h0, ch_en[i]};
        end
        for (int k = 1; k <= adcst_pkg::NUM_CH; k++) begin
            pos_expected[k] = (4'(k) <= en_count);
        end
    end

    // Duplicates leave fewer claimed positions than channels, so the mask comparison
    // catches shared positions as well as gaps.
    assign order_fault = (|ch_bad_order) || (pos_used != pos_expected); // RL10 RL12
    assign scan_fault = scan_mode_multi && ((ch_en == '0) || (|ch_bad_order)); // RL5
    assign pin_fault = |ch_pin_clash; // RL14
    assign cfg_error = (cfg.cal_select == adcst_pkg::CAL_INVALID) || // RL15
                       (scan_mode_multi && !cfg.single_cycle_select); // RL16
    assign any_fault = scan_fault || order_fault || pin_fault || cfg_error;

    ////////////////////////////////////////////////////////////////////////////
    // State update.

    adcst_pkg::adcst_state_t s_q;
    adcst_pkg::adcst_state_t s_d;

    // Next-state logic for power state, ready flags, reference window and status word.
    always_comb begin
        logic [1:0] pd_code;
        logic ref_flag;
        logic mod_busy;
        pd_code = adcst_pkg::PD_STANDBY;
        ref_flag = 1'b0;
        mod_busy = 1'b0;
        s_d = s_q;
        s_d.abort = 1'b0;

        // Power state sequencing.
        case (s_q.pstate)
            adcst_pkg::PS_RESET: begin
                if (s_q.rst_cnt == adcst_pkg::RESET_HOLD_CYCLES - 3'h1) begin
                    s_d.pstate = adcst_pkg::PS_STANDBY;
                end else begin
                    s_d.rst_cnt = s_q.rst_cnt + 3'h1;
                end
            end
            adcst_pkg::PS_STANDBY: begin
                if (evt.sleep_req) begin
                    s_d.pstate = adcst_pkg::PS_SLEEP;
                end else if (evt.conv_cmd && any_fault) begin
                    s_d.abort = 1'b1; // RL6 RL13 RL17
                end else if (evt.conv_cmd) begin
                    s_d.pstate = adcst_pkg::PS_CONVERT;
                end
            end
            adcst_pkg::PS_CONVERT: begin
                // A fault appearing mid-conversion drops back to standby.
                if (any_fault) begin
                    s_d.pstate = adcst_pkg::PS_STANDBY; // RL13 RL14 RL17
                    s_d.abort = 1'b1;
                end else if (evt.conv_done) begin
                    s_d.pstate = adcst_pkg::PS_STANDBY;
                end
            end
            adcst_pkg::PS_SLEEP: begin
                if (!evt.sleep_req) begin
                    s_d.pstate = adcst_pkg::PS_STANDBY;
                end
            end
            default: begin
                s_d.pstate = adcst_pkg::PS_STANDBY;
            end
        endcase

        // Reference settle counter runs only inside conversion and saturates.
        if (s_d.pstate != adcst_pkg::PS_CONVERT) begin
            s_d.ref_cnt = 13'h0000; // RL9
        end else if (s_q.ref_cnt != REF_VALID_CYCLES) begin
            s_d.ref_cnt = s_q.ref_cnt + 13'h0001;
        end

        // Channel ready flags: scan start and reads clear, a new result wins over both.
        if (evt.scan_start) begin
            s_d.srdy = '0; // RL4
        end
        if (evt.data_read_done && (evt.read_chan < 3'(adcst_pkg::NUM_CH))) begin
            s_d.srdy[evt.read_chan] = 1'b0; // RL3
        end
        if (evt.result_new && scan_mode_multi && (evt.result_chan < 3'(adcst_pkg::NUM_CH))) begin
            s_d.srdy[evt.result_chan] = 1'b1; // RL2
        end

        // Single ready flag of sequencer mode one.
        if (evt.result_new && (cfg.scan_mode == adcst_pkg::MODE_SEQ1)) begin
            s_d.rdy = 1'b1; // RL18
        end else if (evt.data_read_done) begin
            s_d.rdy = 1'b0; // RL18
        end

        // Status word fields derived from the next state, so the word stays coherent.
        case (s_d.pstate)
            adcst_pkg::PS_RESET: pd_code = adcst_pkg::PD_RESET;
            adcst_pkg::PS_CONVERT: pd_code = adcst_pkg::PD_CONVERSION;
            adcst_pkg::PS_SLEEP: pd_code = adcst_pkg::PD_SLEEP;
            default: pd_code = adcst_pkg::PD_STANDBY;
        endcase
        ref_flag = (s_d.pstate == adcst_pkg::PS_CONVERT) && evt.ref_ok; // RL7 RL8
        mod_busy = (s_d.pstate == adcst_pkg::PS_CONVERT) || evt.cal_busy; // RL19

        // The word has no write path; every bit comes from internal state.
        s_d.status = 24'h000000; // RL20
        s_d.status[adcst_pkg::BIT_RESET_ACTIVE] = (s_d.pstate == adcst_pkg::PS_RESET); // RL1
        s_d.status[adcst_pkg::SRDY_LSB +: adcst_pkg::NUM_CH] = s_d.srdy;
        s_d.status[adcst_pkg::BIT_SCAN_FAULT] = scan_fault;
        s_d.status[adcst_pkg::BIT_REF_PRESENT] = ref_flag;
        s_d.status[adcst_pkg::BIT_ORDER_FAULT] = order_fault;
        s_d.status[adcst_pkg::BIT_PIN_FAULT] = pin_fault;
        s_d.status[adcst_pkg::BIT_CFG_ERROR] = cfg_error;
        s_d.status[adcst_pkg::PDSTAT_LSB +: 2] = pd_code;
        s_d.status[adcst_pkg::BIT_MOD_BUSY] = mod_busy;
        s_d.status[adcst_pkg::BIT_RDY] = s_d.rdy;
    end

    // State register; reset enters the reset power state.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            s_q.pstate <= adcst_pkg::PS_RESET; // RL1
            s_q.rst_cnt <= 3'h0;
            s_q.ref_cnt <= 13'h0000;
            s_q.srdy <= '0;
            s_q.rdy <= 1'b0;
            s_q.abort <= 1'b0;
            s_q.status <= adcst_pkg::STATUS_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs.
    assign device_status = s_q.status;
    assign conv_abort = s_q.abort;
    assign standby_hold = s_q.status[adcst_pkg::BIT_SCAN_FAULT] ||
                          s_q.status[adcst_pkg::BIT_ORDER_FAULT] ||
                          s_q.status[adcst_pkg::BIT_PIN_FAULT] ||
                          s_q.status[adcst_pkg::BIT_CFG_ERROR];
    assign reference_valid = (s_q.pstate == adcst_pkg::PS_CONVERT) &&
                             (s_q.ref_cnt == REF_VALID_CYCLES); // RL9

    ////////////////////////////////////////////////////////////////////////////
    // Assertions and cover points.

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    AST_RESET_FLAG: assert property ( // RL1
        device_status[adcst_pkg::BIT_RESET_ACTIVE] == (s_q.pstate == adcst_pkg::PS_RESET))
        else $error("Reset flag disagrees with power state.");

    AST_SRDY_SET: assert property ( // RL2
        evt.result_new && scan_mode_multi && (evt.result_chan < 3'h6)
        |=> device_status[adcst_pkg::SRDY_LSB + $past(evt.result_chan)])
        else $error("Channel ready bit not set after new result.");

    AST_SRDY_CLR: assert property ( // RL3
        evt.data_read_done && !evt.result_new && (evt.read_chan < 3'h6)
        |=> !device_status[adcst_pkg::SRDY_LSB + $past(evt.read_chan)])
        else $error("Channel ready bit not cleared after read.");

    AST_SCAN_CLR: assert property ( // RL4
        evt.scan_start && !evt.result_new |=> (s_q.srdy == '0))
        else $error("Ready bits not cleared at scan start.");

    AST_SCAN_FAULT: assert property ( // RL5
        scan_mode_multi && (ch_en == '0) |=> device_status[adcst_pkg::BIT_SCAN_FAULT])
        else $error("Empty channel map not flagged in scan mode.");

    AST_ABORT: assert property ( // RL6
        (s_q.pstate == adcst_pkg::PS_STANDBY) && evt.conv_cmd && !evt.sleep_req && scan_fault
        |=> conv_abort && (s_q.pstate == adcst_pkg::PS_STANDBY))
        else $error("Conversion command not aborted under scan fault.");

    AST_REF_IDLE: assert property ( // RL8
        (s_q.pstate == adcst_pkg::PS_STANDBY) || (s_q.pstate == adcst_pkg::PS_SLEEP)
        |-> !device_status[adcst_pkg::BIT_REF_PRESENT])
        else $error("Reference flag set outside conversion.");

    AST_ORDER_BAD: assert property ( // RL11
        |ch_bad_order |=> device_status[adcst_pkg::BIT_ORDER_FAULT])
        else $error("Forbidden order code not flagged.");

    AST_HOLD_STBY: assert property ( // RL13
        order_fault |=> (s_q.pstate != adcst_pkg::PS_CONVERT))
        else $error("Conversion running under order fault.");

    AST_CFG_ERR: assert property ( // RL15
        (cfg.cal_select == adcst_pkg::CAL_INVALID) |=> device_status[adcst_pkg::BIT_CFG_ERROR])
        else $error("Invalid calibration select not flagged.");

    AST_BUSY: assert property ( // RL19
        (s_q.pstate == adcst_pkg::PS_CONVERT) |-> device_status[adcst_pkg::BIT_MOD_BUSY])
        else $error("Modulator busy low during conversion.");

    AST_RESET_EXIT: assert property ( // RL1
        $fell(device_status[adcst_pkg::BIT_RESET_ACTIVE]) |-> $past(s_q.rst_cnt) == 3'h3)
        else $error("Reset state left at wrong count.");

    AST_ORDER_DUP: assert property ( // RL10
        ch_en[0] && ch_en[1] &&
        (cfg.chan[0].channel_order_code == cfg.chan[1].channel_order_code)
        |=> device_status[adcst_pkg::BIT_ORDER_FAULT])
        else $error("Shared order position not flagged.");

    AST_ORDER_GAP: assert property ( // RL12
        (ch_en == 6'h01) && (cfg.chan[0].channel_order_code != 3'h1)
        |=> device_status[adcst_pkg::BIT_ORDER_FAULT])
        else $error("Lone channel not at order one.");

    AST_PIN_CLASH: assert property ( // RL14
        cfg.chan[0].channel_pin_drive_enable && cfg.chan[1].channel_pin_drive_enable &&
        (cfg.chan[0].pin_sel == cfg.chan[1].pin_sel)
        |=> device_status[adcst_pkg::BIT_PIN_FAULT] && standby_hold)
        else $error("Output pin clash does not hold standby.");

    AST_CFG_SCYC: assert property ( // RL16
        scan_mode_multi && !cfg.single_cycle_select
        |=> device_status[adcst_pkg::BIT_CFG_ERROR])
        else $error("Single cycle select zero in scan mode not flagged.");

    AST_CFG_STBY: assert property ( // RL17
        device_status[adcst_pkg::BIT_CFG_ERROR] |-> (s_q.pstate != adcst_pkg::PS_CONVERT))
        else $error("Conversion running under configuration error.");

    AST_RDY_SET: assert property ( // RL18
        evt.result_new && (cfg.scan_mode == adcst_pkg::MODE_SEQ1)
        |=> device_status[adcst_pkg::BIT_RDY])
        else $error("Single ready flag not set in mode one.");

    AST_SRDY_MODE1: assert property ( // RL2
        evt.result_new && !scan_mode_multi && !evt.scan_start && !evt.data_read_done
        |=> $stable(s_q.srdy))
        else $error("Channel ready bit changed outside scan modes.");

    AST_REF_SET: assert property ( // RL7
        (s_q.pstate == adcst_pkg::PS_CONVERT) && evt.ref_ok && !any_fault && !evt.conv_done
        |=> device_status[adcst_pkg::BIT_REF_PRESENT])
        else $error("Reference flag low with good reference in conversion.");

    AST_RO_ZERO: assert property ( // RL20
        !device_status[23] && (device_status[10:4] == 7'h00))
        else $error("Unused status bits not zero.");

    AST_START_OK: assert property ( // RL7
        (s_q.pstate == adcst_pkg::PS_STANDBY) && evt.conv_cmd && !evt.sleep_req && !any_fault
        |=> !conv_abort && (s_q.pstate == adcst_pkg::PS_CONVERT))
        else $error("Fault-free conversion command not started.");

    COV_CONVERT: cover property ((s_q.pstate == adcst_pkg::PS_STANDBY) ##1
        (s_q.pstate == adcst_pkg::PS_CONVERT) ##[1:20] (s_q.pstate == adcst_pkg::PS_STANDBY));
    COV_ABORT: cover property (conv_abort);
    COV_SRDY_ALL: cover property (s_q.srdy == 6'h3F);
    COV_REF_VALID: cover property (reference_valid && device_status[adcst_pkg::BIT_REF_PRESENT]);

endmodule : adcst_status

// ==== dv/adcst_host_model.sv ====
// Host controller model that reads the status word and the channel data registers.
`timescale 1ns/1ps
module adcst_host_model (
    input wire logic core_clk,
    input wire logic [23:0] device_status,
    input wire logic reference_valid,
    output logic data_read_done,
    output logic [2:0] read_chan,
    output logic ref_trusted
);
    // The reference flag is believed only once the settle window of a conversion has elapsed.
    assign ref_trusted = reference_valid & device_status[adcst_pkg::BIT_REF_PRESENT];

    // Nothing is being read at time zero.
    initial begin
        data_read_done = 1'b0;
        read_chan = 3'h0;
    end

    // Takes the status word as it stands after the last edge.
    task automatic read_status(output logic [23:0] word);
        word = device_status;
    endtask : read_status

    // Reads one channel data register to its end; the index then shows its inverse.
    task automatic read_data(input logic [2:0] ch);
        read_chan = ch;
        data_read_done = 1'b1;
        @(posedge core_clk);
        #1;
        data_read_done = 1'b0;
        read_chan = ~ch;
    endtask : read_data
endmodule : adcst_host_model

// ==== dv/tb_adcst_status.sv ====
// Self-checking testbench for the converter status register block.
`timescale 1ns/1ps
`define check_eq(got, exp) begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
        num_errors++; \
        $display("CHECK FAILED at %0t ns: got %h expected %h", $time, (got), (exp)); \
    end \
end
module tb_adcst_status;
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    adcst_pkg::adcst_cfg_t cfg;
    adcst_pkg::adcst_evt_t evt_r;
    adcst_pkg::adcst_evt_t evt;
    logic [23:0] device_status;
    logic conv_abort;
    logic standby_hold;
    logic reference_valid;
    logic data_read_done;
    logic [2:0] read_chan;
    logic ref_trusted;
    logic [23:0] st;
    int num_errors = 0;
    int tests_run = 0;

    ////////////////////////////////////////////////////////////////////////////////
    // The clock runs at 200 MHz.
    always #2.5 core_clk = ~core_clk;

    // Bench events merged with the read strobe that the host model drives.
    always_comb begin
        evt = evt_r;
        evt.data_read_done = data_read_done;
        evt.read_chan = read_chan;
    end

    adcst_status #(.REF_VALID_CYCLES(13'h14)) uut (
        .core_clk(core_clk),
        .reset(reset),
        .cfg(cfg),
        .evt(evt),
        .device_status(device_status),
        .conv_abort(conv_abort),
        .standby_hold(standby_hold),
        .reference_valid(reference_valid)
    );

    adcst_host_model host (
        .core_clk(core_clk),
        .device_status(device_status),
        .reference_valid(reference_valid),
        .data_read_done(data_read_done),
        .read_chan(read_chan),
        .ref_trusted(ref_trusted)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Advances a number of edges and lands just after the last one.
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : step

    // Sets the mode fields and the first two channel entries; all else cleared.
    task automatic cfg_set(input logic [1:0] mode, input logic scyc, input logic [1:0] cal,
                           input logic en0, input logic [2:0] o0, input logic en1,
                           input logic [2:0] o1);
        cfg = '0;
        cfg.scan_mode = mode;
        cfg.single_cycle_select = scyc;
        cfg.cal_select = cal;
        cfg.chan[0].channel_scan_enable = en0;
        cfg.chan[0].channel_order_code = o0;
        cfg.chan[1].channel_scan_enable = en1;
        cfg.chan[1].channel_order_code = o1;
    endtask : cfg_set

    // Checks one fault bit, then tries a conversion that must be refused on a fault.
    task automatic fault_case(input int bitn, input logic exp);
        step(1);
        host.read_status(st);
        `check_eq(st[bitn], exp)
        `check_eq(standby_hold, exp)
        `check_eq({st[23], st[10:4]}, 8'h00)
        evt_r.conv_cmd = 1'b1;
        step(1);
        evt_r.conv_cmd = 1'b0;
        host.read_status(st);
        `check_eq(conv_abort, exp)
        `check_eq(st[3:2] == adcst_pkg::PD_STANDBY, exp)
        evt_r.conv_done = 1'b1;
        step(1);
        evt_r.conv_done = 1'b0;
        step(1);
    endtask : fault_case

    // Prints the verdict and ends the run.
    task automatic end_of_test();
        if (num_errors == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_of_test

    ////////////////////////////////////////////////////////////////////////////////
    // Cuts a hang short well past the expected hundred or so cycles.
    initial begin
        #(2000 * 5);
        num_errors++;
        end_of_test();
    end

    // Main sequence of scenarios.
    initial begin
        evt_r = '0;
        cfg_set(adcst_pkg::MODE_SEQ1, 1'b1, 2'h0, 1'b0, 3'h0, 1'b0, 3'h0);
        step(10);
        `check_eq(device_status, adcst_pkg::STATUS_RESET)
        `check_eq(reference_valid, 1'b0)
        reset = 1'b0;
        step(4);
        `check_eq(device_status, 24'h000008)
        step(1);
        cfg.cal_select = adcst_pkg::CAL_INVALID;
        fault_case(adcst_pkg::BIT_CFG_ERROR, 1'b1);
        cfg_set(adcst_pkg::MODE_SEQ2, 1'b0, 2'h0, 1'b1, 3'h1, 1'b0, 3'h0);
        fault_case(adcst_pkg::BIT_CFG_ERROR, 1'b1);
        cfg_set(adcst_pkg::MODE_SEQ2, 1'b1, 2'h0, 1'b0, 3'h0, 1'b0, 3'h0);
        fault_case(adcst_pkg::BIT_SCAN_FAULT, 1'b1);
        cfg_set(adcst_pkg::MODE_SEQ3, 1'b1, 2'h0, 1'b1, 3'h7, 1'b0, 3'h0);
        fault_case(adcst_pkg::BIT_SCAN_FAULT, 1'b1);
        cfg_set(adcst_pkg::MODE_SEQ1, 1'b1, 2'h0, 1'b0, 3'h0, 1'b0, 3'h0);
        fault_case(adcst_pkg::BIT_SCAN_FAULT, 1'b0);
        cfg_set(adcst_pkg::MODE_SEQ1, 1'b1, 2'h0, 1'b1, 3'h1, 1'b1, 3'h1);
        fault_case(adcst_pkg::BIT_ORDER_FAULT, 1'b1);
        cfg_set(adcst_pkg::MODE_SEQ1, 1'b1, 2'h0, 1'b1, 3'h0, 1'b0, 3'h0);
        fault_case(adcst_pkg::BIT_ORDER_FAULT, 1'b1);
        cfg_set(adcst_pkg::MODE_SEQ1, 1'b1, 2'h0, 1'b1, 3'h1, 1'b1, 3'h3);
        fault_case(adcst_pkg::BIT_ORDER_FAULT, 1'b1);
        cfg_set(adcst_pkg::MODE_SEQ1, 1'b1, 2'h0, 1'b1, 3'h2, 1'b1, 3'h1);
        fault_case(adcst_pkg::BIT_ORDER_FAULT, 1'b0);
        cfg_set(adcst_pkg::MODE_SEQ1, 1'b1, 2'h0, 1'b0, 3'h0, 1'b0, 3'h0);
        cfg.chan[0].channel_pin_drive_enable = 1'b1;
        cfg.chan[0].pin_sel = 2'h1;
        cfg.chan[1].channel_pin_drive_enable = 1'b1;
        cfg.chan[1].pin_sel = 2'h1;
        fault_case(adcst_pkg::BIT_PIN_FAULT, 1'b1);
        cfg.chan[1].pin_sel = 2'h2;
        fault_case(adcst_pkg::BIT_PIN_FAULT, 1'b0);
        // Scan conversion with reference detection and per-channel ready flags.
        cfg_set(adcst_pkg::MODE_SEQ2, 1'b1, 2'h0, 1'b1, 3'h1, 1'b1, 3'h2);
        evt_r.ref_ok = 1'b1;
        evt_r.conv_cmd = 1'b1;
        step(1);
        evt_r.conv_cmd = 1'b0;
        host.read_status(st);
        `check_eq(st[3:1], 3'h1)
        step(8);
        `check_eq(reference_valid, 1'b0)
        step(25);
        host.read_status(st);
        `check_eq(st[14], 1'b1)
        `check_eq(ref_trusted, 1'b1)
        evt_r.ref_ok = 1'b0;
        step(2);
        host.read_status(st);
        `check_eq({st[14], st[3:2]}, 3'h0)
        evt_r.result_new = 1'b1;
        evt_r.result_chan = 3'h1;
        step(1);
        evt_r.result_new = 1'b0;
        host.read_status(st);
        `check_eq({st[21:16], st[0]}, 7'h04)
        host.read_data(3'h1);
        host.read_status(st);
        `check_eq(st[17], 1'b0)
        evt_r.result_new = 1'b1;
        evt_r.result_chan = 3'h0;
        step(1);
        evt_r.result_new = 1'b0;
        evt_r.scan_start = 1'b1;
        step(1);
        evt_r.scan_start = 1'b0;
        host.read_status(st);
        `check_eq(st[21:16], 6'h00)
        evt_r.ref_ok = 1'b1;
        evt_r.conv_done = 1'b1;
        step(1);
        evt_r.conv_done = 1'b0;
        host.read_status(st);
        `check_eq({st[14], st[3:1], reference_valid}, 5'h08)
        // Single result flag in mode one, then calibration busy and sleep.
        cfg_set(adcst_pkg::MODE_SEQ1, 1'b1, 2'h0, 1'b0, 3'h0, 1'b0, 3'h0);
        evt_r.result_new = 1'b1;
        evt_r.result_chan = 3'h3;
        step(1);
        evt_r.result_new = 1'b0;
        host.read_status(st);
        `check_eq({st[21:16], st[0]}, 7'h01)
        host.read_data(3'h3);
        host.read_status(st);
        `check_eq(st[0], 1'b0)
        evt_r.cal_busy = 1'b1;
        step(1);
        host.read_status(st);
        `check_eq(st[1], 1'b1)
        evt_r.cal_busy = 1'b0;
        evt_r.sleep_req = 1'b1;
        step(2);
        host.read_status(st);
        `check_eq({st[14], st[3:2]}, 3'h1)
        evt_r.sleep_req = 1'b0;
        step(2);
        reset = 1'b1;
        step(1);
        `check_eq(device_status, adcst_pkg::STATUS_RESET)
        reset = 1'b0;
        step(2);
        `check_eq(device_status, adcst_pkg::STATUS_RESET)
        end_of_test();
    end
endmodule : tb_adcst_status
